/* File: design/rtc_ctrl_regs.v */
`timescale 1ns/1ps
`include "rtc_ctrl_defines.vh"

// Operation
// - Update pending low guarantees 244us quiet time
// - Setting update inhibit blocks updates, clears pending
// - Divider bits: 01x runs, 11x holds chain
// - First update 500ms after run pattern
// - Rate field picks tap or disables it
// - Update once per second unless inhibited
// - Periodic flag sets regardless of its enable
// - Alarm flag on match, top bits wildcard
// - Inhibit going high clears update interrupt enable
// - Square wave toggles at tap or held low
// - Square wave enable forced on at power-up
// - Data format bit selects binary or BCD
// - Hour format bit selects 24 or 12 hours
// - April first Sunday jumps 1:59:59 to 3:00:00
// - October last Sunday returns once to 1:00:00
// - Combined flag ORs six pairs, drives request low
// - Reading flag register clears three flags
// - Periodic flag set on selected tap edge
// - Update ended flag set after each update
// - Battery valid read-only, other bits read zero
// - Bank zero maps clock, bank one extended RAM
// - Read flags double latched, new events held
// - Control registers always reachable in both banks
module rtc_ctrl_regs #(
   parameter OSC_DIV = `OSC_DIV_DEFAULT,
   parameter PRE_W   = 12
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        vcc_good,
   input  wire        battery_valid,
   input  wire        fixed_32k_select,
   input  wire        wakeup_flag,
   input  wire        wakeup_irq_enable,
   input  wire        kickstart_flag,
   input  wire        kickstart_irq_enable,
   input  wire        ram_clear_flag,
   input  wire        ram_clear_irq_enable,
   input  wire [7:0]  cur_sec,
   input  wire [7:0]  cur_min,
   input  wire [7:0]  cur_hour,
   input  wire [7:0]  cur_dow,
   input  wire [7:0]  cur_date,
   input  wire [7:0]  cur_month,
   input  wire [7:0]  alm_sec,
   input  wire [7:0]  alm_min,
   input  wire [7:0]  alm_hour,
   output reg         update_tick,
   output reg         dst_forward_pulse,
   output reg         dst_back_pulse,
   output reg         bank_selector,
   output reg         data_format_sel,
   output reg         hour_24_sel,
   output reg         square_wave_out,
   output wire        irq_o,
   output reg         irq_oe
);

   localparam integer UIP_START_I = `UIP_START;
   localparam [14:0]  UIP_START   = UIP_START_I[14:0];
   localparam integer PRE_LAST_I  = OSC_DIV - 1;
   localparam [PRE_W-1:0] PRE_LAST = PRE_LAST_I[PRE_W-1:0];
   // Reset images of the two writable control registers.
   localparam [7:0]   A_INIT      = `A_RESET & `A_RW_MASK;
   localparam [7:0]   B_INIT      = `B_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   function [7:0] bcd2bin;
      input [7:0] v;
      begin
         bcd2bin = {1'b0, v[7:4], 3'b000} + {3'b000, v[7:4], 1'b0} + {4'h0, v[3:0]};
      end
   endfunction

   // Constant held in BCD, returned in the selected data format.
   function [7:0] enc;
      input       binary;
      input [7:0] v;
      begin
         enc = binary ? bcd2bin(v) : v;
      end
   endfunction

   function alarm_hit;
      input [7:0] alarm;
      input [7:0] cur;
      begin
         alarm_hit = (alarm[7:6] == `ALARM_ANY) || (alarm == cur);
      end
   endfunction

   // Chain bit whose square wave matches the rate code.
   function [3:0] tap_index;
      input [3:0] rs;
      begin
         if (rs == `RS_CODE1) begin
            tap_index = `TAP_CODE1;
         end else if (rs == `RS_CODE2) begin
            tap_index = `TAP_CODE2;
         end else begin
            tap_index = rs - `TAP_OFFSET;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.

   reg [6:0]       div_rate_reg;
   reg             set_reg;
   reg             pie_reg;
   reg             aie_reg;
   reg             uie_reg;
   reg             square_wave_enable_reg;
   reg             dse_reg;
   reg             pf_reg;
   reg             af_reg;
   reg             uf_reg;
   reg             combined_request_flag_reg;
   reg             uip_reg;
   reg [7:0]       rdata_reg;
   reg [PRE_W-1:0] pre_cnt_reg;
   reg [14:0]      chain_reg;
   reg             tap_prev_reg;
   reg             toggle32_reg;
   reg             vcc_prev_reg;
   reg             fall_done_reg;
   reg             update_done_reg;

   wire       setup_phase = psel & ~penable;
   wire       access      = psel & penable;
   wire       sel_a       = (paddr == `ADDR_DIV_RATE);
   wire       sel_b       = (paddr == `ADDR_MODE_IRQ);
   wire       sel_c       = (paddr == `ADDR_FLAGS);
   wire       sel_d       = (paddr == `ADDR_BATT);
   wire       mapped      = sel_a | sel_b | sel_c | sel_d;
   wire       wr_a        = access & pwrite & sel_a;
   wire       wr_b        = access & pwrite & sel_b;
   wire       rd_c        = access & ~pwrite & sel_c;
   wire [1:0] dv          = div_rate_reg[`A_DV_HI:`A_DV_LO];
   wire [3:0] rs          = div_rate_reg[`A_RS_HI:`A_RS_LO];
   wire       osc_on      = dv[0];
   wire       running     = (dv == `DV_RUN);
   wire       osc_tick    = osc_on & (pre_cnt_reg == PRE_LAST);
   wire       wrap        = osc_tick & running & (chain_reg == `CHAIN_LAST);
   wire       set_now     = wr_b ? pwdata[`B_SET] : set_reg;
   wire       do_update   = wrap & ~set_now;
   wire       tap_now     = chain_reg[tap_index(rs)];
   wire       rate_on     = (rs != `RS_OFF) & running;
   wire       pf_set      = rate_on & tap_now & ~tap_prev_reg;

   // The registers answer in the first access cycle, in either bank.
   assign pready  = 1'b1;
   // Unmapped offsets are refused with an error and read back as zero.
   assign pslverr = access & ~mapped;
   assign prdata  = {24'h000000, rdata_reg};
   // The request pin is open drain, so only its enable ever moves.
   assign irq_o   = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Read snapshot, taken in the setup cycle so the flags read stay stable.

   reg [7:0] rd_mux;

   always @* begin
      rd_mux = 8'h00;
      if (sel_a) begin
         rd_mux = {uip_reg, div_rate_reg};
      end else if (sel_b) begin
         rd_mux = {set_reg, pie_reg, aie_reg, uie_reg,
                   square_wave_enable_reg, data_format_sel, hour_24_sel, dse_reg};
      end else if (sel_c) begin
         rd_mux = {combined_request_flag_reg, pf_reg, af_reg, uf_reg, 4'h0};
      end else if (sel_d) begin
         rd_mux = {battery_valid, 7'h00};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 8'h00;
      end else if (setup_phase) begin
         rdata_reg <= pwrite ? 8'h00 : rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_rate_reg    <= A_INIT[6:0];
         set_reg         <= B_INIT[`B_SET];
         pie_reg         <= 1'b0;
         aie_reg         <= 1'b0;
         uie_reg         <= 1'b0;
         square_wave_enable_reg        <= 1'b0;
         data_format_sel <= 1'b0;
         hour_24_sel     <= 1'b0;
         dse_reg         <= 1'b0;
         bank_selector   <= 1'b0;
         vcc_prev_reg    <= 1'b0;
      end else begin
         vcc_prev_reg <= vcc_good;
         if (wr_a) begin
            div_rate_reg  <= pwdata[6:0];
            bank_selector <= pwdata[`A_BANK];
         end
         // A write that raises the inhibit bit also drops the update-ended enable.
         if (wr_b) begin
            set_reg         <= pwdata[`B_SET];
            pie_reg         <= pwdata[`B_PIE];
            aie_reg         <= pwdata[`B_AIE];
            data_format_sel <= pwdata[`B_DM];
            hour_24_sel     <= pwdata[`B_HOUR24];
            dse_reg         <= pwdata[`B_DSE];
            square_wave_enable_reg        <= pwdata[`B_SQUARE_WAVE_ENABLE];
            if (pwdata[`B_SET] & ~set_reg) begin
               uie_reg <= 1'b0;
            end else begin
               uie_reg <= pwdata[`B_UIE];
            end
         end
         if (vcc_good & ~vcc_prev_reg) begin
            square_wave_enable_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crystal prescaler and the countdown chain.
   // Each prescaler wrap stands for one crystal period.

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_reg  <= {PRE_W{1'b0}};
         toggle32_reg <= 1'b0;
      end else if (!osc_on) begin
         pre_cnt_reg <= {PRE_W{1'b0}};
      end else if (osc_tick) begin
         pre_cnt_reg  <= {PRE_W{1'b0}};
         toggle32_reg <= ~toggle32_reg;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 1'b1;
      end
   end

   // A held chain sits half way, so the first update comes 500ms after run.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_reg <= `CHAIN_HALF;
      end else if (!running) begin
         chain_reg <= `CHAIN_HALF;
      end else if (osc_tick) begin
         chain_reg <= chain_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Update cycle and update pending status.

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uip_reg         <= 1'b0;
         update_tick     <= 1'b0;
         update_done_reg <= 1'b0;
      end else begin
         update_tick     <= do_update;
         update_done_reg <= update_tick;
         // Pending rises ahead of the wrap and falls when the update ends.
         if (set_now) begin
            uip_reg <= 1'b0;
         end else if (running & (chain_reg >= UIP_START)) begin
            uip_reg <= 1'b1;
         end else if (update_done_reg | ~running) begin
            uip_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Daylight saving jumps, judged on the time before it advances.

   wire dm         = data_format_sel;
   wire at_159     = (cur_hour == enc(dm, `HOUR_ONE)) &&
                     (cur_min == enc(dm, `MINSEC_LAST)) &&
                     (cur_sec == enc(dm, `MINSEC_LAST));
   wire is_sunday  = (cur_dow == `DOW_SUNDAY);
   wire spring_day = is_sunday && (cur_month == enc(dm, `MONTH_APR)) &&
                     (cur_date <= enc(dm, `DATE_WEEK1_LAST));
   wire is_oct     = (cur_month == enc(dm, `MONTH_OCT));
   wire fall_day   = is_sunday && is_oct &&
                     (cur_date >= enc(dm, `DATE_LASTWK_MIN));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dst_forward_pulse <= 1'b0;
         dst_back_pulse    <= 1'b0;
         fall_done_reg     <= 1'b0;
      end else begin
         dst_forward_pulse <= do_update & dse_reg & spring_day & at_159;
         dst_back_pulse    <= 1'b0;
         if (!is_oct) begin
            fall_done_reg <= 1'b0;
         end else if (do_update & dse_reg & fall_day & at_159 & ~fall_done_reg) begin
            dst_back_pulse <= 1'b1;
            fall_done_reg  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt flags; a new event wins over the read that clears.

   wire alarm_now = alarm_hit(alm_sec, cur_sec) && alarm_hit(alm_min, cur_min) &&
                    alarm_hit(alm_hour, cur_hour);
   wire clr_pf    = rd_c & rdata_reg[`C_PF];
   wire clr_af    = rd_c & rdata_reg[`C_AF];
   wire clr_uf    = rd_c & rdata_reg[`C_UF];
   // The combined flag and the pin enable follow the six pairs a clock later.
   wire combined  = (pf_reg & pie_reg) | (af_reg & aie_reg) | (uf_reg & uie_reg) |
                    (wakeup_flag & wakeup_irq_enable) |
                    (kickstart_flag & kickstart_irq_enable) |
                    (ram_clear_flag & ram_clear_irq_enable);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_reg       <= 1'b0;
         af_reg       <= 1'b0;
         uf_reg       <= 1'b0;
         combined_request_flag_reg     <= 1'b0;
         irq_oe       <= 1'b0;
         tap_prev_reg <= 1'b0;
      end else begin
         tap_prev_reg <= tap_now;
         pf_reg       <= (pf_reg & ~clr_pf) | pf_set;
         af_reg       <= (af_reg & ~clr_af) | (update_done_reg & alarm_now);
         uf_reg       <= (uf_reg & ~clr_uf) | update_done_reg;
         combined_request_flag_reg     <= combined;
         irq_oe       <= combined;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Square wave pin.
   // The fixed 32 kHz select overrides both the enable and the rate.

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         square_wave_out <= 1'b0;
      end else if (fixed_32k_select) begin
         square_wave_out <= toggle32_reg;
      end else if (square_wave_enable_reg & rate_on) begin
         square_wave_out <= tap_now;
      end else begin
         square_wave_out <= 1'b0;
      end
   end

endmodule

/* File: design/rtc_ctrl_defines.vh */
`ifndef RTC_CTRL_DEFINES_VH
`define RTC_CTRL_DEFINES_VH

// Clocking and the crystal divider.
`define PCLK_HZ          100000000
`define OSC_HZ           32768
`define OSC_DIV_DEFAULT  ((`PCLK_HZ + `OSC_HZ / 2) / `OSC_HZ)
`define CHAIN_W          15
`define CHAIN_LAST       15'h7FFF
`define CHAIN_HALF       15'h4000
`define UIP_GUARD_US     244
`define UIP_GUARD_TICKS  ((`UIP_GUARD_US * `OSC_HZ + 999999) / 1000000)
`define UIP_START        (32767 - `UIP_GUARD_TICKS - 1)

// Register byte addresses.
`define ADDR_DIV_RATE    8'h00
`define ADDR_MODE_IRQ    8'h04
`define ADDR_FLAGS       8'h08
`define ADDR_BATT        8'h0C

// Divider and rate control fields.
`define A_UIP            7
`define A_DV_HI          6
`define A_DV_LO          5
`define A_BANK           4
`define A_RS_HI          3
`define A_RS_LO          0
`define A_RW_MASK        8'h7F
`define A_RESET          8'h00
`define DV_RUN           2'b01
`define RS_OFF           4'h0

// Mode and interrupt enable fields.
`define B_SET            7
`define B_PIE            6
`define B_AIE            5
`define B_UIE            4
`define B_SQUARE_WAVE_ENABLE           3
`define B_DM             2
`define B_HOUR24         1
`define B_DSE            0
`define B_RESET          8'h00

// Flag and battery fields.
`define C_COMBINED_REQUEST_FLAG           7
`define C_PF             6
`define C_AF             5
`define C_UF             4
`define D_VRT            7

// Divider taps.
`define TAP_CODE1        4'h6
`define TAP_CODE2        4'h7
`define TAP_OFFSET       4'h2
`define RS_CODE1         4'h1
`define RS_CODE2         4'h2

// Calendar constants, in BCD form.
`define ALARM_ANY        2'b11
`define MONTH_APR        8'h04
`define MONTH_OCT        8'h10
`define DATE_WEEK1_LAST  8'h07
`define DATE_LASTWK_MIN  8'h25
`define DOW_SUNDAY       8'h01
`define HOUR_ONE         8'h01
`define MINSEC_LAST      8'h59

`endif

/* File: dv/rtc_ctrl_regs_assertions.sv */
`timescale 1ns/1ps
`include "rtc_ctrl_defines.vh"
module rtc_ctrl_regs_assertions (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        wakeup_flag,
   input wire        wakeup_irq_enable,
   input wire        update_tick,
   input wire        dst_forward_pulse,
   input wire        dst_back_pulse,
   input wire        bank_selector,
   input wire        data_format_sel,
   input wire        hour_24_sel,
   input wire        irq_o,
   input wire        irq_oe
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel && penable && pready;
wire wa  = acc && pwrite && paddr == `ADDR_DIV_RATE;
wire wb  = acc && pwrite && paddr == `ADDR_MODE_IRQ;
wire hit = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
////////////////////////////////////////////////////////////////////////////////
property p_slverr; psel && penable && !hit |-> pslverr && (pwrite || prdata == 32'h0); endproperty
a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
property p_bank; wa |=> bank_selector == $past(pwdata[4]); endproperty
a_bank: assert property (p_bank) else $error("bank select not taken");
property p_fmt;
   wb |=> data_format_sel == $past(pwdata[2]) && hour_24_sel == $past(pwdata[1]);
endproperty
a_fmt: assert property (p_fmt) else $error("format bits not taken");
property p_pair; wakeup_flag && wakeup_irq_enable |-> ##[1:2] irq_oe; endproperty
a_pair: assert property (p_pair) else $error("request not raised");
property p_wire; wakeup_flag && wakeup_irq_enable |=> irq_oe && irq_o == 1'b0; endproperty
a_wire: assert property (p_wire) else $error("request line not low");
property p_fwd; dst_forward_pulse |-> update_tick; endproperty
a_fwd: assert property (p_fwd) else $error("forward jump off update");
property p_back; dst_back_pulse |-> update_tick && !dst_forward_pulse; endproperty
a_back: assert property (p_back) else $error("back jump off update");
property p_tick; update_tick |=> !update_tick [*8]; endproperty
a_tick: assert property (p_tick) else $error("update too soon");
property p_rsvd;
   acc && !pwrite |-> prdata[31:8] == 24'h0 && (paddr != `ADDR_FLAGS || prdata[3:0] == 4'h0)
      && (paddr != `ADDR_BATT || prdata[6:0] == 7'h0);
endproperty
a_rsvd: assert property (p_rsvd) else $error("unused bits not zero");
c_tick: cover property (update_tick);
c_fwd: cover property (dst_forward_pulse);
c_irq: cover property ($rose(irq_oe));
endmodule
bind rtc_ctrl_regs rtc_ctrl_regs_assertions rtc_ctrl_regs_assertions_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wakeup_flag(wakeup_flag), .wakeup_irq_enable(wakeup_irq_enable),
   .update_tick(update_tick), .dst_forward_pulse(dst_forward_pulse),
   .dst_back_pulse(dst_back_pulse), .bank_selector(bank_selector),
   .data_format_sel(data_format_sel), .hour_24_sel(hour_24_sel), .irq_o(irq_o),
   .irq_oe(irq_oe)
);

/* File: dv/rtc_time_model.sv */
`timescale 1ns/1ps
`include "rtc_ctrl_defines.vh"
module rtc_time_model (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       update_tick,
   input  wire       dst_forward_pulse,
   input  wire       dst_back_pulse,
   output logic [7:0] cur_sec,
   output logic [7:0] cur_min,
   output logic [7:0] cur_hour,
   output logic [7:0] cur_dow,
   output logic [7:0] cur_date,
   output logic [7:0] cur_month
);
// Starts one second before the spring jump on the first Sunday of April.
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      {cur_month, cur_date, cur_dow, cur_hour, cur_min, cur_sec} <=
         {`MONTH_APR, 8'h01, `DOW_SUNDAY, `HOUR_ONE, `MINSEC_LAST, `MINSEC_LAST};
   end else if (dst_forward_pulse) begin
      {cur_hour, cur_min, cur_sec} <= {8'h03, 16'h0000};
   end else if (dst_back_pulse) begin
      {cur_hour, cur_min, cur_sec} <= {8'h01, 16'h0000};
   end else if (update_tick) begin
      cur_sec <= cur_sec + 8'h01;
   end
end
endmodule

/* File: dv/test_rtc_ctrl_regs.sv */
`timescale 1ns/1ps
`include "rtc_ctrl_defines.vh"
module test_rtc_ctrl_regs;
logic        pclk, presetn, psel, penable, pwrite, vcc_good, battery_valid, fwd;
logic        fixed_32k_select;
logic [7:0]  paddr;
logic [31:0] pwdata, rng;
logic [5:0]  ext;
logic [31:0] exp_q[$];
int          num_errors, num_checks, ticks, n, t;
wire [31:0]  prdata;
wire         pready, pslverr, update_tick, dst_forward_pulse, dst_back_pulse, bank_selector;
wire         data_format_sel, hour_24_sel, square_wave_out, irq_o, irq_oe;
wire [7:0]   cur_sec, cur_min, cur_hour, cur_dow, cur_date, cur_month;
rtc_ctrl_regs #(.OSC_DIV(4)) rtc_ctrl_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .vcc_good, .battery_valid,
   .fixed_32k_select, .wakeup_flag(ext[0]), .wakeup_irq_enable(ext[1]),
   .kickstart_flag(ext[2]), .kickstart_irq_enable(ext[3]), .ram_clear_flag(ext[4]),
   .ram_clear_irq_enable(ext[5]), .cur_sec, .cur_min, .cur_hour, .cur_dow, .cur_date,
   .cur_month, .alm_sec(8'hC0), .alm_min(8'hC0), .alm_hour(8'hC0), .update_tick,
   .dst_forward_pulse, .dst_back_pulse, .bank_selector, .data_format_sel, .hour_24_sel,
   .square_wave_out, .irq_o, .irq_oe);
rtc_time_model rtc_time_model_inst (.pclk, .presetn, .update_tick, .dst_forward_pulse,
   .dst_back_pulse, .cur_sec, .cur_min, .cur_hour, .cur_dow, .cur_date, .cur_month);
always #5 pclk = ~pclk;
////////////////////////////////////////////////////////////////////////////////
function automatic [31:0] xs(input [31:0] v);
   v = v ^ (v << 13);
   v = v ^ (v >> 17);
   return v ^ (v << 5);
endfunction
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
   num_checks++;
   if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
   end
endtask
task complete_run;
   $display("checks %0d mismatches %0d", num_checks, num_errors);
   if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
endtask
// A read notes its expected byte; the monitor below compares it.
task apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
   logic err;
   err = !(a == `ADDR_DIV_RATE || a == `ADDR_MODE_IRQ || a == `ADDR_FLAGS || a == `ADDR_BATT);
   @(posedge pclk);
   psel <= 1'b1;
   penable <= 1'b0;
   pwrite <= w;
   paddr <= a;
   pwdata <= {24'h0, d};
   if (!w) exp_q.push_back({24'h0, e});
   @(posedge pclk);
   penable <= 1'b1;
   do begin
      @(posedge pclk);
   end while (pready !== 1'b1);
   chk("pslverr", pslverr, err);
   psel <= 1'b0;
   penable <= 1'b0;
endtask
task cnt;
   logic s;
   t = 0;
   @(negedge pclk);
   s = square_wave_out;
   repeat (64) begin
      @(negedge pclk);
      if (square_wave_out !== s) t++;
      s = square_wave_out;
   end
endtask
always @(posedge pclk) begin
   if (psel && penable && pready === 1'b1 && !pwrite)
      chk("prdata", prdata, exp_q.pop_front());
   if (update_tick === 1'b1) begin
      ticks <= ticks + 1;
      fwd <= dst_forward_pulse;
   end
end
initial begin
   #900000;
   num_errors++;
   complete_run;
end
initial begin
   {pclk, presetn, psel, penable, pwrite, vcc_good, fixed_32k_select, ext, paddr, pwdata} = '0;
   {battery_valid, rng, ticks, fwd} = {1'b1, 32'd85397, 32'd0, 1'b0};
   repeat (16) @(posedge pclk);
   presetn <= 1'b1;
   apb(0, `ADDR_DIV_RATE, 0, 8'h00);
   apb(0, `ADDR_MODE_IRQ, 0, 8'h00);
   apb(1, `ADDR_DIV_RATE, 8'hFF, 0);
   apb(0, `ADDR_DIV_RATE, 0, 8'h7F);
   apb(1, `ADDR_MODE_IRQ, 8'h10, 0);
   apb(1, `ADDR_MODE_IRQ, 8'h90, 0);
   apb(0, `ADDR_MODE_IRQ, 0, 8'h80);
   apb(1, `ADDR_MODE_IRQ, 8'h00, 0);
   vcc_good <= 1'b1;
   apb(0, `ADDR_MODE_IRQ, 0, 8'h08);
   apb(0, `ADDR_BATT, 0, 8'h80);
   battery_valid <= 1'b0;
   apb(1, `ADDR_BATT, 8'hFF, 0);
   apb(1, `ADDR_FLAGS, 8'hFF, 0);
   apb(0, `ADDR_BATT, 0, 8'h00);
   apb(0, `ADDR_FLAGS, 0, 8'h00);
   apb(0, 8'h10, 0, 8'h00);
   $display("test registers done");
   for (n = 0; n < 8; n++) begin
      rng = xs(rng);
      ext <= rng[5:0];
      repeat (3) @(posedge pclk);
      t = (rng[0] & rng[1]) | (rng[2] & rng[3]) | (rng[4] & rng[5]);
      chk("irq_oe", irq_oe, t);
      apb(0, `ADDR_FLAGS, 0, {t[0], 7'h00});
   end
   ext <= 6'h00;
   $display("test combined request done");
   apb(1, `ADDR_MODE_IRQ, 8'h31, 0);
   apb(1, `ADDR_DIV_RATE, 8'h20, 0);
   for (n = 0; n < 80000 && ticks == 0; n++) @(posedge pclk);
   repeat (4) @(posedge pclk);
   chk("ticks", ticks, 1);
   chk("forward", fwd, 1);
   chk("hour", cur_hour, 8'h03);
   chk("irq_oe", irq_oe, 1);
   apb(0, `ADDR_FLAGS, 0, 8'hB0);
   apb(0, `ADDR_FLAGS, 0, 8'h00);
   repeat (2) @(posedge pclk);
   chk("irq_oe", irq_oe, 0);
   $display("test update done");
   apb(1, `ADDR_DIV_RATE, 8'h23, 0);
   repeat (64) @(posedge pclk);
   apb(0, `ADDR_FLAGS, 0, 8'h40);
   apb(1, `ADDR_MODE_IRQ, 8'h48, 0);
   repeat (32) @(posedge pclk);
   chk("irq_oe", irq_oe, 1);
   cnt;
   chk("toggles", t >= 7 && t <= 9, 1);
   apb(1, `ADDR_MODE_IRQ, 8'h40, 0);
   repeat (2) @(posedge pclk);
   cnt;
   chk("held low", {t[30:0], square_wave_out}, 0);
   @(posedge pclk);
   fixed_32k_select <= 1'b1;
   cnt;
   chk("fixed 32k", t >= 15 && t <= 17, 1);
   $display("test periodic done");
   complete_run;
end
endmodule
